// >>> dv/nand_dev_model.sv
/* Behavioural NAND device: byte log, busy timer and per-plane status.
   Assumes pins change on the host clock and fail_i is set before confirm. */
`timescale 1ns/1ps
module nand_dev_model #(parameter int BUSY = 60) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [7:0] bus_i,
   input wire logic ce_n_i,
   input wire logic cle_i,
   input wire logic ale_i,
   input wire logic we_n_i,
   input wire logic re_n_i,
   input wire logic [1:0] fail_i,
   output logic [7:0] io_o,
   output logic rb_n_o,
   output logic [127:0] log_o
);
   logic we_q, stat_q, enh_q, pl_q, rdy;
   logic [1:0] fl_q;
   logic [2:0] na_q;
   int cnt_q;
   assign rdy = cnt_q == 0;
   assign rb_n_o = rdy;
   // Bytes latch on write strobe rise; a released bus toggles every cycle.
   always_ff @(posedge clk_i) begin
      we_q <= we_n_i;
      io_o <= ~io_o;
      if (cnt_q > 0)
         cnt_q <= cnt_q - 1;
      if (cnt_q == 1)
         fl_q <= fail_i;
      if (!ce_n_i && !re_n_i && stat_q)
         io_o <= {1'b1, rdy, rdy, 4'h0,
                  enh_q ? fl_q[pl_q] : |fl_q};
      if (srst_i) begin
         cnt_q <= 0;
         stat_q <= 1'b0;
         fl_q <= 2'h0;
         io_o <= 8'h00;
         log_o <= '0;
         na_q <= 3'h0;
      end else if (!we_q && we_n_i && !ce_n_i) begin
         log_o <= {log_o[119:0], bus_i};
         na_q <= ale_i ? na_q + 3'h1 : 3'h0;
         if (ale_i && na_q == 3'h0)
            pl_q <= bus_i[6];
         if (cle_i && (rdy || bus_i[7:4] == 4'h7)) begin
            stat_q <= bus_i[7:4] == 4'h7;
            enh_q <= bus_i == 8'h78;
            if (bus_i == 8'hd0 || bus_i == 8'h10)
               cnt_q <= BUSY;
            if (bus_i == 8'h35)
               cnt_q <= BUSY + 20;
            if (bus_i == 8'h11)
               cnt_q <= 8;
         end
      end
   end
endmodule

// >>> dv/nand_mp_host_assertions.sv
/* Checker for the multiplane NAND host pins and user port.
   Assumes it is bound to the host top module and sees its ports only. */
`timescale 1ns/1ps
module nand_mp_chk (
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic req_valid_i,
   input wire logic req_ready_o,
   input wire logic done_o,
   input wire logic fail_o,
   input wire logic [7:0] status_o,
   input wire logic status_valid_o,
   input wire logic [7:0] io_i,
   input wire logic [7:0] io_o,
   input wire logic io_oe_o,
   input wire logic ce_n_o,
   input wire logic cle_o,
   input wire logic ale_o,
   input wire logic we_n_o,
   input wire logic read_strobe_n_o,
   input wire logic ready_busy_n_i
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (srst_i);
   a_take_blocks: assert property (req_valid_i && req_ready_o |=> !req_ready_o)
      else $error("second request accepted while one is running");
   a_write_width: assert property ($fell(we_n_o) |-> !we_n_o [*6] ##1 we_n_o)
      else $error("write strobe low time wrong");
   a_bus_at_latch: assert property ($rose(we_n_o) |->
      io_oe_o && $stable(io_o) && !ce_n_o)
      else $error("bus not held at write latch edge");
   a_cmd_addr_excl: assert property (!(cle_o && ale_o))
      else $error("command and address latch both high");
   a_read_no_drive: assert property (!read_strobe_n_o |->
      !io_oe_o && we_n_o && !ce_n_o)
      else $error("host drives bus during a read cycle");
   a_status_sample: assert property (status_valid_o |->
      status_o == $past(io_i) && !$past(read_strobe_n_o))
      else $error("status sample not taken from the bus");
   a_fail_at_done: assert property (done_o |-> fail_o == status_o[0])
      else $error("fail flag differs from status bit zero");
   a_quiet_busy: assert property (!ready_busy_n_i |-> we_n_o)
      else $error("write cycle while device busy");
   c_fail_seen: cover property (done_o && fail_o);
   c_ready_status: cover property (status_valid_o && status_o[6]);
   c_cmd_latch: cover property ($rose(we_n_o) && cle_o);
endmodule
bind nand_mp_host nand_mp_chk u_nand_mp_chk (.mclk_i(mclk_i), .srst_i(srst_i),
   .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .done_o(done_o), .fail_o(fail_o),
   .status_o(status_o), .status_valid_o(status_valid_o), .io_i(io_i), .io_o(io_o),
   .io_oe_o(io_oe_o), .ce_n_o(ce_n_o), .cle_o(cle_o), .ale_o(ale_o), .we_n_o(we_n_o),
   .read_strobe_n_o(read_strobe_n_o), .ready_busy_n_i(ready_busy_n_i));

// >>> dv/test_nand_mp_host.sv
/* Random and corner-case bench for the multiplane NAND host.
   Assumes the device model in nand_dev_model and the package constants. */
`timescale 1ns/1ps
module test_nand_mp_host;
   import nand_mp_pkg::*;
   logic mclk_i = 1'b0;
   logic srst_i = 1'b1;
   logic req_valid_i = 1'b0;
   req_s req_i = '0;
   req_s r;
   logic [7:0] patch_data_i = 8'h00;
   logic req_ready_o, done_o, fail_o, status_valid_o, patch_take_o, io_oe_o, ce_n_o;
   logic cle_o, ale_o, we_n_o, read_strobe_n_o, rb_n;
   logic [7:0] status_o, io_o, dev_io, bus;
   logic [1:0] fail = 2'h0;
   logic [127:0] log;
   logic [7:0] pd [4];
   logic [7:0] q [$];
   logic [23:0] blk;
   int bad_count = 0;
   int comparisons = 0;
   int pi = 0;
   // The host wins the shared wire while its enable is high.
   assign bus = io_oe_o ? io_o : dev_io;
   initial forever #2.5 mclk_i = ~mclk_i;
   nand_mp_host u_nand_mp_host (.mclk_i(mclk_i), .srst_i(srst_i), .req_valid_i(req_valid_i),
      .req_i(req_i), .patch_data_i(patch_data_i), .poll_stop_i(1'b0), .req_ready_o(req_ready_o),
      .done_o(done_o), .fail_o(fail_o), .status_o(status_o), .status_valid_o(status_valid_o),
      .patch_take_o(patch_take_o), .io_i(bus), .io_o(io_o), .io_oe_o(io_oe_o), .ce_n_o(ce_n_o),
      .cle_o(cle_o), .ale_o(ale_o), .we_n_o(we_n_o), .read_strobe_n_o(read_strobe_n_o),
      .ready_busy_n_i(rb_n));
   nand_dev_model u_nand_dev_model (.clk_i(mclk_i), .srst_i(srst_i), .bus_i(bus),
      .ce_n_i(ce_n_o), .cle_i(cle_o), .ale_i(ale_o), .we_n_i(we_n_o), .re_n_i(read_strobe_n_o),
      .fail_i(fail), .io_o(dev_io), .rb_n_o(rb_n), .log_o(log));
   // Offers the next patch byte once the host has taken one.
   always @(negedge mclk_i)
      if (patch_take_o === 1'b1 && pi < 3) begin
         pi = pi + 1;
         patch_data_i = pd[pi];
      end
   task automatic check(string what, logic [127:0] seen, logic [127:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   function automatic void put_addr(logic [15:0] c, logic [23:0] rw, bit row_only);
      if (!row_only) begin
         q.push_back(c[7:0]);
         q.push_back(c[15:8]);
      end
      q.push_back(rw[7:0]);
      q.push_back(rw[15:8]);
      q.push_back(rw[23:16]);
   endfunction
   // Issues r, waits for completion and compares the bytes the device latched with q.
   task automatic run(string name);
      logic [127:0] e;
      logic [127:0] m;
      e = '0;
      foreach (q[i])
         e = {e[119:0], q[i]};
      m = q.size() >= 16 ? '1 : (128'h1 << (8 * q.size())) - 128'h1;
      @(negedge mclk_i);
      req_i = r;
      req_valid_i = 1'b1;
      pi = 0;
      patch_data_i = pd[0];
      for (int t = 0; t < 200 && req_ready_o !== 1'b1; t++)
         @(negedge mclk_i);
      @(negedge mclk_i);
      req_valid_i = 1'b0;
      for (int t = 0; t < 5000 && done_o !== 1'b1; t++)
         @(negedge mclk_i);
      check("op done", done_o, 1'b1);
      check(name, log & m, e);
      $display("finished %s", name);
   endtask
   task automatic cb_read(bit p);
      r.op = OP_CB_READ;
      r.row_a = {blk[23:7], p, blk[5:0]};
      q = {CMD_CB_READ0};
      put_addr(r.col, r.row_a, 0);
      q.push_back(CMD_CB_READ);
      run("copy read");
   endtask
   initial begin
      repeat (60000) @(posedge mclk_i);
      bad_count++;
      give_verdict();
   end
   initial begin
      void'($urandom(44988));
      repeat (16) @(negedge mclk_i);
      check("reset pins", {ce_n_o, we_n_o, read_strobe_n_o, io_oe_o}, 4'he);
      srst_i = 1'b0;
      r = '0;
      // Back-to-back two-plane erases over all plane outcomes, then status reads.
      for (int k = 0; k < 4; k++) begin
         blk = $urandom;
         fail = k[1:0];
         r.op = OP_ERASE2;
         r.row_a = {blk[23:7], 7'h00};
         r.row_b = {blk[23:7], 7'h40};
         q = {CMD_ERASE_SETUP};
         put_addr(r.col, r.row_a, 1);
         q.push_back(CMD_ERASE_SETUP);
         put_addr(r.col, r.row_b, 1);
         q.push_back(CMD_ERASE_CONF);
         q.push_back(CMD_STATUS);
         run("erase");
         check("erase fail", fail_o, |fail);
         check("erase ready", status_o[6], 1'b1);
         r.op = OP_STATUS_ENH;
         r.row_a = k[0] ? r.row_b : r.row_a;
         q = {CMD_STATUS_ENH};
         put_addr(r.col, r.row_a, 1);
         run("plane status");
         check("plane fail", fail_o, fail[k[0]]);
         r.op = OP_STATUS;
         q = {CMD_STATUS};
         run("status");
         check("composite fail", fail_o, |fail);
      end
      // Copy-back: reads from both planes, a two-plane copy, then a patched copy.
      fail = 2'h0;
      blk = $urandom;
      r.col = $urandom;
      cb_read(0);
      cb_read(1);
      r.op = OP_CB_PROG2;
      r.row_a = {~blk[23:7], 1'b0, blk[5:0]};
      r.row_b = {~blk[23:7], 1'b1, blk[5:0]};
      q = {CMD_CB_PROG};
      put_addr(r.col, r.row_a, 0);
      q.push_back(CMD_DUMMY_CONF);
      q.push_back(CMD_CB_PROG);
      put_addr(r.col, r.row_b, 0);
      q.push_back(CMD_PROG_CONF);
      q.push_back(CMD_STATUS);
      run("two-plane copy");
      cb_read(1);
      r.op = OP_CB_PROG;
      r.patch_len = 8'(1 + $urandom % 3);
      r.row_a = {~blk[23:7], 1'b1, blk[5:0]};
      q = {CMD_CB_PROG};
      put_addr(r.col, r.row_a, 0);
      for (int i = 0; i < 4; i++) begin
         pd[i] = $urandom;
         if (i < r.patch_len)
            q.push_back(pd[i]);
      end
      q.push_back(CMD_PROG_CONF);
      q.push_back(CMD_STATUS);
      run("patched copy");
      check("copy pass", fail_o, 1'b0);
      r.op = OP_READ_RESUME;
      q = {CMD_READ};
      run("resume read");
      give_verdict();
   end
endmodule

// >>> logic/nand_mp_host.sv
/*
 Host controller for multiplane erase, copy-back and status reads on a NAND.
 Assumes the NAND pins are synchronous to mclk_i and that the user holds a
 request stable while it is pending.
*/
`timescale 1ns/1ps
// Summary of operation
// RULE1: Erase: two setup codes, three addresses, confirm.
// RULE2: Second erase block follows first without waiting.
// RULE3: First block plane bit zero, second one.
// RULE4: Block bits equal apart from plane bit.
// RULE5: Either failing erase block sets fail bit.
// RULE6: Completion seen on busy pin and status.
// RULE7: Status read allowed during dummy busy.
// RULE8: Interrupted erase blocks re-erased before use.
// RULE9: Copy-back read loads whole source page.
// RULE10: Copy-back read adds extra busy time.
// RULE11: After ready: read out or program copy.
// RULE12: Copy-back source and target share plane.
// RULE13: Copy-back pages pair by equal parity.
// RULE14: Patch data allowed before program confirm.
// RULE15: Interrupted copy program page erased first.
// RULE16: Multiplane copy needs two single reads first.
// RULE17: Status driven from later falling edge.
// RULE18: Multiplane fail bit is OR of planes.
// RULE19: Status updates while read strobe stays low.
// RULE20: Status mode holds; resume needs read code.
// RULE21: Stacked dies use enhanced status read.
// RULE22: Enhanced status names plane and die.
// RULE23: Fail bit zero pass, one fail.
// RULE24: During erase only status commands allowed.
module nand_mp_host (
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic req_valid_i,
   input wire nand_mp_pkg::req_s req_i,
   input wire logic [7:0] patch_data_i,
   input wire logic poll_stop_i,
   output logic req_ready_o,
   output logic done_o,
   output logic fail_o,
   output logic [7:0] status_o,
   output logic status_valid_o,
   output logic patch_take_o,
   input wire logic [7:0] io_i,
   output logic [7:0] io_o,
   output logic io_oe_o,
   output logic ce_n_o,
   output logic cle_o,
   output logic ale_o,
   output logic we_n_o,
   output logic read_strobe_n_o,
   input wire logic ready_busy_n_i
);
   import nand_mp_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE, ST_CMD, ST_ADDR, ST_DATA, ST_WAIT_RB, ST_POLL, ST_NEXT
   } state_e;

   // Step list: each step is a command cycle, or a run of address or data bus cycles.
   typedef enum logic [1:0] { K_CMD, K_ADDR, K_DATA } kind_e;

   state_e st_q, st_d;
   req_s req_q, req_d;
   logic [3:0] step_q, step_d;
   logic [2:0] acnt_q, acnt_d;
   logic [7:0] pcnt_q, pcnt_d;
   logic [7:0] tcnt_q, tcnt_d;
   logic phase_q, phase_d;
   logic [7:0] io_q, io_d;
   logic oe_q, oe_d;
   logic ce_n_q, ce_n_d, cle_q, cle_d, ale_q, ale_d, we_n_q, we_n_d, re_n_q, re_n_d;
   logic rdy_q, rdy_d, done_q, done_d, fail_q, fail_d, sv_q, sv_d, take_q, take_d;
   logic [7:0] stat_q, stat_d;

   // Sequence table: the code, kind and address count of each step of an op.
   function automatic logic [7:0] step_code(input op_e op, input logic [3:0] s);
      step_code = ZERO8;
      case (op)
         OP_ERASE2: step_code = (s == 4'h0 || s == 4'h2) ? CMD_ERASE_SETUP : CMD_ERASE_CONF;
         OP_CB_READ: step_code = (s == 4'h0) ? CMD_CB_READ0 : CMD_CB_READ; // [RULE16]
         OP_CB_PROG: step_code = (s == 4'h0) ? CMD_CB_PROG : CMD_PROG_CONF;
         OP_CB_PROG2: step_code = (s == 4'h0 || s == 4'h3) ? CMD_CB_PROG :
                                  (s == 4'h2) ? CMD_DUMMY_CONF : CMD_PROG_CONF;
         OP_STATUS: step_code = CMD_STATUS;
         OP_STATUS_ENH: step_code = CMD_STATUS_ENH; // [RULE21]
         OP_READ_RESUME: step_code = CMD_READ;
         default: step_code = ZERO8;
      endcase
   endfunction

   // Kind of step s; ops with no address or data steps report K_CMD for every step.
   function automatic kind_e step_kind(input op_e op, input logic [3:0] s);
      step_kind = K_CMD;
      case (op)
         OP_ERASE2: step_kind = s[0] ? K_ADDR : K_CMD;
         OP_CB_READ, OP_STATUS_ENH: step_kind = s[0] ? K_ADDR : K_CMD;
         OP_CB_PROG: step_kind = (s == 4'h1) ? K_ADDR : (s == 4'h2) ? K_DATA : K_CMD;
         OP_CB_PROG2: step_kind = (s == 4'h1 || s == 4'h4) ? K_ADDR : K_CMD;
         default: step_kind = K_CMD;
      endcase
   endfunction

   function automatic logic [3:0] step_last(input op_e op);
      case (op)
         OP_ERASE2: step_last = 4'h4;
         OP_CB_READ: step_last = 4'h2;
         OP_CB_PROG: step_last = 4'h3;
         OP_CB_PROG2: step_last = 4'h5;
         OP_STATUS_ENH: step_last = 4'h1;
         default: step_last = 4'h0;
      endcase
   endfunction

   // Address byte of the current address step; 2nd erase/program uses row_b.
   function automatic logic [7:0] addr_byte(input req_s r, input logic [3:0] s,
                                            input logic [2:0] a);
      logic [23:0] row;
      logic [39:0] full;
      row = (s >= 4'h3) ? r.row_b : r.row_a; // [RULE3] [RULE4] [RULE12] [RULE13]
      full = {row, r.col};
      addr_byte = ZERO8;
      if (r.op == OP_ERASE2 || r.op == OP_STATUS_ENH) begin
         addr_byte = row[8*a +: 8];
      end else begin
         addr_byte = full[8*a +: 8];
      end
   endfunction

   function automatic logic [2:0] addr_count(input op_e op);
      if (op == OP_ERASE2) begin
         addr_count = 3'(BLK_ADDR_CYCLES); // [RULE1]
      end else if (op == OP_STATUS_ENH) begin
         addr_count = 3'(ENH_ADDR_CYCLES); // [RULE22]
      end else begin
         addr_count = 3'(PAGE_ADDR_CYCLES);
      end
   endfunction

   // Next-state logic for the sequencer and all pin registers.
   always_comb begin
      st_d = st_q;
      req_d = req_q;
      step_d = step_q;
      acnt_d = acnt_q;
      pcnt_d = pcnt_q;
      tcnt_d = tcnt_q;
      phase_d = phase_q;
      io_d = io_q;
      oe_d = oe_q;
      ce_n_d = ce_n_q;
      cle_d = 1'b0;
      ale_d = 1'b0;
      we_n_d = 1'b1;
      re_n_d = 1'b1;
      rdy_d = 1'b0;
      done_d = 1'b0;
      fail_d = fail_q;
      sv_d = 1'b0;
      take_d = 1'b0;
      stat_d = stat_q;
      case (st_q)
         ST_IDLE: begin
            rdy_d = 1'b1;
            ce_n_d = 1'b1;
            oe_d = 1'b0;
            if (req_valid_i && rdy_q) begin
               req_d = req_i;
               step_d = 4'h0;
               rdy_d = 1'b0;
               ce_n_d = 1'b0;
               st_d = ST_NEXT;
            end
         end
         ST_NEXT: begin
            tcnt_d = STROBE_CNT;
            phase_d = 1'b0;
            acnt_d = ZERO3;
            pcnt_d = req_q.patch_len;
            case (step_kind(req_q.op, step_q))
               K_CMD: st_d = ST_CMD;
               K_ADDR: st_d = ST_ADDR;
               default: st_d = ST_DATA;
            endcase
         end
         ST_CMD, ST_ADDR, ST_DATA: begin
            // One write strobe: low phase then high phase of STROBE_CNT + 1 cycles each.
            cle_d = (st_q == ST_CMD);
            ale_d = (st_q == ST_ADDR);
            oe_d = 1'b1;
            if (st_q == ST_CMD) begin
               io_d = step_code(req_q.op, step_q);
            end else if (st_q == ST_ADDR) begin
               io_d = addr_byte(req_q, step_q, acnt_q);
            end else begin
               io_d = patch_data_i; // [RULE14]
            end
            we_n_d = phase_q;
            tcnt_d = tcnt_q - 8'h01;
            if (st_q == ST_DATA && pcnt_q == ZERO8) begin
               // Empty patch: confirm follows directly.
               we_n_d = 1'b1;
               step_d = step_q + 4'h1;
               st_d = ST_NEXT;
            end else if (tcnt_q == ZERO8) begin
               tcnt_d = STROBE_CNT;
               phase_d = ~phase_q;
               if (phase_q) begin
                  take_d = (st_q == ST_DATA);
                  if (st_q == ST_ADDR && acnt_q + 3'h1 < addr_count(req_q.op)) begin
                     acnt_d = acnt_q + 3'h1;
                  end else if (st_q == ST_DATA && pcnt_q > 8'h01) begin
                     pcnt_d = pcnt_q - 8'h01;
                  end else if (step_q == step_last(req_q.op)) begin
                     tcnt_d = WB_CNT;
                     oe_d = 1'b0;
                     st_d = (req_q.op == OP_STATUS || req_q.op == OP_STATUS_ENH) ?
                            ST_POLL : ST_WAIT_RB;
                  end else if (req_q.op == OP_CB_PROG2 && step_q == 4'h2) begin
                     // Dummy busy between planes; the second program command follows.
                     tcnt_d = WB_CNT;
                     oe_d = 1'b0;
                     st_d = ST_WAIT_RB;
                  end else begin
                     // Second erase setup follows the first without a wait. [RULE2]
                     step_d = step_q + 4'h1;
                     st_d = ST_NEXT;
                  end
               end
            end
         end
         ST_WAIT_RB: begin
            // Busy pin marks the end of erase, copy read and program. [RULE6] [RULE10]
            // Nothing but status may be sent while the array works. [RULE24]
            oe_d = 1'b0;
            if (tcnt_q != ZERO8) begin
               tcnt_d = tcnt_q - 8'h01;
            end else if (ready_busy_n_i) begin
               if (step_q == step_last(req_q.op)) begin
                  if (req_q.op == OP_CB_READ || req_q.op == OP_READ_RESUME) begin
                     done_d = 1'b1; // [RULE9] [RULE11] [RULE20]
                     st_d = ST_IDLE;
                  end else begin
                     // Confirm status with a plain status read. [RULE5] [RULE18]
                     req_d.op = OP_STATUS;
                     step_d = 4'h0;
                     st_d = ST_NEXT;
                  end
               end else begin
                  step_d = step_q + 4'h1;
                  st_d = ST_NEXT;
               end
            end
         end
         ST_POLL: begin
            // Hold the read strobe low; the value on io tracks the status. [RULE17] [RULE19]
            oe_d = 1'b0;
            re_n_d = 1'b0;
            if (tcnt_q != ZERO8) begin
               tcnt_d = tcnt_q - 8'h01;
            end else begin
               stat_d = io_i;
               sv_d = 1'b1;
               if (io_i[SR_READY_BIT] || poll_stop_i) begin
                  fail_d = io_i[SR_FAIL_BIT]; // [RULE23]
                  done_d = 1'b1;
                  re_n_d = 1'b1;
                  st_d = ST_IDLE;
               end
            end
         end
         default: st_d = ST_IDLE;
      endcase
   end

   // Register stage for all sequencer state and pins. A reset abandons a running erase
   // or program; the user must erase those blocks again before trusting them. [RULE8] [RULE15]
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         st_q <= ST_IDLE;
         req_q <= '0;
         step_q <= 4'h0;
         acnt_q <= ZERO3;
         pcnt_q <= ZERO8;
         tcnt_q <= ZERO8;
         phase_q <= 1'b0;
         io_q <= ZERO8;
         oe_q <= 1'b0;
         ce_n_q <= 1'b1;
         cle_q <= 1'b0;
         ale_q <= 1'b0;
         we_n_q <= 1'b1;
         re_n_q <= 1'b1;
         rdy_q <= 1'b0;
         done_q <= 1'b0;
         fail_q <= 1'b0;
         sv_q <= 1'b0;
         take_q <= 1'b0;
         stat_q <= ZERO8;
      end else begin
         st_q <= st_d;
         req_q <= req_d;
         step_q <= step_d;
         acnt_q <= acnt_d;
         pcnt_q <= pcnt_d;
         tcnt_q <= tcnt_d;
         phase_q <= phase_d;
         io_q <= io_d;
         oe_q <= oe_d;
         ce_n_q <= ce_n_d;
         cle_q <= cle_d;
         ale_q <= ale_d;
         we_n_q <= we_n_d;
         re_n_q <= re_n_d;
         rdy_q <= rdy_d;
         done_q <= done_d;
         fail_q <= fail_d;
         sv_q <= sv_d;
         take_q <= take_d;
         stat_q <= stat_d;
      end
   end

   // Outputs come straight from the registers above.
   assign req_ready_o = rdy_q;
   assign done_o = done_q;
   assign fail_o = fail_q;
   assign status_o = stat_q;
   assign status_valid_o = sv_q;
   assign patch_take_o = take_q;
   assign io_o = io_q;
   assign io_oe_o = oe_q;
   assign ce_n_o = ce_n_q;
   assign cle_o = cle_q;
   assign ale_o = ale_q;
   assign we_n_o = we_n_q;
   assign read_strobe_n_o = re_n_q;
endmodule

// >>> logic/nand_mp_pkg.sv
/*
 Package for the host-side multiplane/copy-back NAND sequencer: command codes,
 status bit positions, cycle counts and the carrier structs of the user port.
 Assumes a 200 MHz controller clock and an asynchronous NAND on the far side.
*/
package nand_mp_pkg;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
   localparam logic [7:0] CMD_ERASE_CONF = 8'hd0;
   localparam logic [7:0] CMD_CB_READ0 = 8'h00;
   localparam logic [7:0] CMD_CB_READ = 8'h35;
   localparam logic [7:0] CMD_CB_PROG = 8'h85;
   localparam logic [7:0] CMD_DUMMY_CONF = 8'h11;
   localparam logic [7:0] CMD_PROG_CONF = 8'h10;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam logic [7:0] CMD_STATUS_ENH = 8'h78;
   localparam logic [7:0] CMD_READ = 8'h00;
   localparam logic [7:0] CMD_READ_CONF = 8'h30;
   localparam int SR_FAIL_BIT = 0;
   localparam int SR_READY_BIT = 6;
   localparam int BLK_ADDR_CYCLES = 3;
   localparam int PAGE_ADDR_CYCLES = 5;
   localparam int ENH_ADDR_CYCLES = 3;
   localparam int CLK_PERIOD_PS = 5000;
   // Strobe phase length: a minimum time, rounded up to whole cycles.
   localparam int STROBE_NS = 25;
   localparam int STROBE_CYC = (STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Wait before ready/busy is trusted after a busy-causing command.
   localparam int WB_NS = 100;
   localparam int WB_CYC = (WB_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [7:0] STROBE_CNT = 8'(STROBE_CYC);
   localparam logic [7:0] WB_CNT = 8'(WB_CYC);
   localparam logic [2:0] ZERO3 = 3'h0;
   localparam logic [7:0] ZERO8 = 8'h00;

   typedef enum logic [2:0] {
      OP_ERASE2,
      OP_CB_READ,
      OP_CB_PROG,
      OP_CB_PROG2,
      OP_STATUS,
      OP_STATUS_ENH,
      OP_READ_RESUME
   } op_e;

   typedef struct packed {
      op_e op;
      logic [23:0] row_a;
      logic [23:0] row_b;
      logic [15:0] col;
      logic [7:0] patch_len;
   } req_s;

   typedef struct packed {
      logic [7:0] ce_n;
      logic cle;
      logic ale;
      logic we_n;
      logic read_strobe_n;
   } pins_s;
endpackage
